/* File: hw/snfr_top.sv */
/*
 Feature and status register bank of a serial NAND device.
 Assumes a system clock fast enough to oversample the serial pins,
 which pass two flip-flops first, and an array engine that reports
 busy, failures and ECC results as same-clock pulses and levels.
*/
`timescale 1ns/1ps
`include "snfr_defines.svh"
module snfr_top (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic otp_lock_stored_in,
  input wire logic cs_n_in,
  input wire logic sck_in,
  input wire logic sdi_in,
  input wire logic wp_n_in,
  input wire logic eng_busy_in,
  input wire logic read_start_in,
  input wire logic read_done_in,
  input wire logic [3:0] read_ecc_in,
  input wire logic prog_start_in,
  input wire logic prog_fail_in,
  input wire logic erase_start_in,
  input wire logic erase_fail_in,
  input wire logic block_protected_in,
  output logic sdo_out,
  output logic sdo_oe_n_out,
  output logic [7:0] block_protection_reg_out,
  output logic [7:0] device_config_reg_out,
  output logic [1:0] drive_strength_select_out,
  output logic ecc_enable_out,
  output logic quad_io_enable_out,
  output logic write_enable_latch_out,
  output logic otp_lock_commit_out,
  output logic soft_reset_out
);
  // ----------------------------------------------------------------
  // State record
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] prot;
    logic [7:0] cfg;
    logic [7:0] drive;
    logic [1:0] ecc_result;
    logic [1:0] ecc_ext;
    logic prog_fail;
    logic erase_fail;
    logic write_enable_latch;
    logic operation_in_progress;
    logic selected_block_protected;
    logic por_armed;
    logic por_busy;
    logic sdo;
    logic sdo_oe_n;
    logic otp_commit;
    logic soft_reset;
    logic strap_done;
    logic sck_q;
  } snfr_regs_type;

  snfr_regs_type r_ff;
  snfr_regs_type nxt_r;

  // ----------------------------------------------------------------
  // Pin synchronisers and frame engine
  // ----------------------------------------------------------------
  logic cs_n_s;
  logic sck_s;
  logic sdi_s;
  logic wp_n_s;
  logic cs_q_ff;
  logic nxt_cs_q;
  logic sck_rise;
  logic [7:0] opcode;
  logic [7:0] waddr;
  logic [7:0] wdata;
  logic wr_commit;
  logic cmd_done;
  logic [7:0] raddr;
  logic [7:0] rd_byte;
  logic frame_sdo;
  logic frame_oe_n;
  logic [7:0] status_byte;
  logic [7:0] ext_byte;
  logic prot_locked;

  snfr_sync u_sync_cs (.clk_in(clk_in), .rst_in(rst_in),
    .async_in(cs_n_in), .sync_out(cs_n_s));
  snfr_sync u_sync_sck (.clk_in(clk_in), .rst_in(rst_in),
    .async_in(sck_in), .sync_out(sck_s));
  snfr_sync u_sync_sdi (.clk_in(clk_in), .rst_in(rst_in),
    .async_in(sdi_in), .sync_out(sdi_s));
  snfr_sync u_sync_wp (.clk_in(clk_in), .rst_in(rst_in),
    .async_in(wp_n_in), .sync_out(wp_n_s));

  assign sck_rise = sck_s && !r_ff.sck_q;

  snfr_frame u_frame (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .cs_n_in(cs_n_s),
    .cs_fall_in(cs_q_ff && !cs_n_s),
    .sck_rise_in(sck_rise),
    .sdi_in(sdi_s),
    .rd_byte_in(rd_byte),
    .opcode_out(opcode),
    .addr_out(waddr),
    .wr_data_out(wdata),
    .wr_commit_out(wr_commit),
    .cmd_done_out(cmd_done),
    .rd_addr_out(raddr),
    .sdo_out(frame_sdo),
    .sdo_oe_n_out(frame_oe_n)
  );

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always_comb begin
    status_byte = {2'h0, r_ff.ecc_result, r_ff.prog_fail,
      r_ff.erase_fail, r_ff.write_enable_latch, r_ff.operation_in_progress};
    ext_byte = {1'h0, r_ff.ecc_ext, r_ff.selected_block_protected, 4'h0};
    unique case (raddr)
      `SNFR_ADDR_PROT: rd_byte = r_ff.prot;
      `SNFR_ADDR_CONFIG: rd_byte = r_ff.cfg;
      `SNFR_ADDR_STATUS: rd_byte = status_byte;
      `SNFR_ADDR_DRIVE: rd_byte = r_ff.drive;
      `SNFR_ADDR_EXT: rd_byte = ext_byte;
      default: rd_byte = 8'h00;
    endcase
  end

  assign prot_locked = (r_ff.prot[`SNFR_PROT_LOCK_BIT] && !wp_n_s) ||
    r_ff.cfg[`SNFR_CFG_BPL_BIT];

  // ----------------------------------------------------------------
  // Register update
  // ----------------------------------------------------------------
  always_comb begin
    nxt_r = r_ff;
    nxt_cs_q = cs_n_s;
    nxt_r.sck_q = sck_s;
    nxt_r.otp_commit = 1'b0;
    nxt_r.soft_reset = 1'b0;
    nxt_r.sdo = frame_sdo;
    nxt_r.sdo_oe_n = frame_oe_n;
    // Catch the stored OTP lock once after reset release
    if (!r_ff.strap_done) begin
      nxt_r.strap_done = 1'b1;
      nxt_r.cfg[`SNFR_CFG_OTP_LOCK_BIT] = otp_lock_stored_in;
    end
    // Set-feature commit at chip select rise
    if (wr_commit && !r_ff.por_busy) begin
      unique case (waddr)
        `SNFR_ADDR_PROT: begin
          if (!prot_locked) begin
            nxt_r.prot = wdata & `SNFR_PROT_MASK;
          end
        end
        `SNFR_ADDR_CONFIG: begin
          nxt_r.cfg = (wdata & `SNFR_CFG_MASK) |
            {r_ff.cfg[`SNFR_CFG_OTP_LOCK_BIT], 7'h00};
          if (r_ff.cfg[`SNFR_CFG_BPL_BIT]) begin
            nxt_r.cfg[`SNFR_CFG_BPL_BIT] = 1'b1;
          end
        end
        `SNFR_ADDR_DRIVE: nxt_r.drive = wdata & `SNFR_DRIVE_MASK;
        default: begin
          // Read-only or undefined address: no effect
        end
      endcase
    end
    // Single-byte commands take effect at chip select rise
    if (cmd_done && !r_ff.por_busy) begin
      nxt_r.por_armed = 1'b0;
      unique case (opcode)
        `SNFR_OP_WRITE_ENABLE: nxt_r.write_enable_latch = 1'b1;
        `SNFR_OP_WRITE_DISABLE: nxt_r.write_enable_latch = 1'b0;
        `SNFR_OP_SOFT_RESET: begin
          // Soft reset keeps protection, config and drive
          nxt_r.write_enable_latch = 1'b0;
          nxt_r.prog_fail = 1'b0;
          nxt_r.erase_fail = 1'b0;
          nxt_r.ecc_result = `SNFR_ECC_NONE;
          nxt_r.ecc_ext = `SNFR_ECC_NONE;
          nxt_r.soft_reset = 1'b1;
        end
        `SNFR_OP_POR_ENABLE: nxt_r.por_armed = 1'b1;
        `SNFR_OP_POR: begin
          if (r_ff.por_armed) begin
            nxt_r.prot = `SNFR_PROT_RESET;
            nxt_r.cfg = `SNFR_CFG_RESET |
              {r_ff.cfg[`SNFR_CFG_OTP_LOCK_BIT], 7'h00};
            nxt_r.drive = `SNFR_DRIVE_RESET;
            nxt_r.write_enable_latch = 1'b0;
            nxt_r.prog_fail = 1'b0;
            nxt_r.erase_fail = 1'b0;
            nxt_r.selected_block_protected = 1'b1;
            nxt_r.ecc_result = `SNFR_ECC_NONE;
            nxt_r.ecc_ext = `SNFR_ECC_NONE;
            nxt_r.por_busy = 1'b1;
            nxt_r.soft_reset = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
    // Array engine events; set wins over clear
    if (read_start_in) begin
      nxt_r.ecc_result = `SNFR_ECC_NONE;
      nxt_r.ecc_ext = `SNFR_ECC_NONE;
    end
    if (read_done_in) begin
      // Also loads the page 0 result after power-on reset
      nxt_r.ecc_result = read_ecc_in[3:2];
      nxt_r.ecc_ext = read_ecc_in[1:0];
    end
    if (prog_start_in) begin
      nxt_r.prog_fail = 1'b0;
      if (r_ff.cfg[`SNFR_CFG_OTP_EN_BIT] &&
          r_ff.cfg[`SNFR_CFG_OTP_LOCK_BIT] && r_ff.write_enable_latch) begin
        nxt_r.otp_commit = 1'b1;
      end
    end
    if (prog_fail_in) begin
      nxt_r.prog_fail = 1'b1;
    end
    if (erase_start_in) begin
      nxt_r.erase_fail = 1'b0;
    end
    if (erase_fail_in) begin
      nxt_r.erase_fail = 1'b1;
    end
    if (prog_start_in || erase_start_in) begin
      nxt_r.write_enable_latch = 1'b0;
    end
    if (r_ff.por_busy && !eng_busy_in && !cmd_done) begin
      nxt_r.por_busy = 1'b0;
    end
    nxt_r.operation_in_progress = eng_busy_in || r_ff.por_busy;
    nxt_r.selected_block_protected = block_protected_in;
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      // Matches the synchroniser's reset output: no false select edge
      cs_q_ff <= 1'b0;
      r_ff <= '{prot: `SNFR_PROT_RESET, cfg: `SNFR_CFG_RESET,
        drive: `SNFR_DRIVE_RESET, ecc_result: `SNFR_ECC_NONE,
        ecc_ext: `SNFR_ECC_NONE, prog_fail: 1'b0, erase_fail: 1'b0,
        write_enable_latch: 1'b0, operation_in_progress: 1'b0, selected_block_protected: 1'b1, por_armed: 1'b0,
        por_busy: 1'b0, sdo: 1'b0, sdo_oe_n: 1'b1, otp_commit: 1'b0,
        soft_reset: 1'b0, strap_done: 1'b0, sck_q: 1'b0};
    end else begin
      cs_q_ff <= nxt_cs_q;
      r_ff <= nxt_r;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign sdo_out = r_ff.sdo;
  assign sdo_oe_n_out = r_ff.sdo_oe_n;
  assign block_protection_reg_out = r_ff.prot;
  assign device_config_reg_out = r_ff.cfg;
  assign drive_strength_select_out = r_ff.drive[6:5];
  assign ecc_enable_out = r_ff.cfg[`SNFR_CFG_ECC_EN_BIT];
  assign quad_io_enable_out = r_ff.cfg[`SNFR_CFG_QE_BIT];
  assign write_enable_latch_out = r_ff.write_enable_latch;
  assign otp_lock_commit_out = r_ff.otp_commit;
  assign soft_reset_out = r_ff.soft_reset;
endmodule

/* File: hw/snfr_defines.svh */
/*
 Feature register bank constants: opcodes, feature addresses, bit
 positions and power-up values. Assumes inclusion by bare name.
*/
`ifndef SNFR_DEFINES_SVH
`define SNFR_DEFINES_SVH

// ----------------------------------------------------------------
// Opcodes
// ----------------------------------------------------------------
`define SNFR_OP_GET_FEATURE 8'h0F
`define SNFR_OP_SET_FEATURE 8'h1F
`define SNFR_OP_WRITE_ENABLE 8'h06
`define SNFR_OP_WRITE_DISABLE 8'h04
`define SNFR_OP_SOFT_RESET 8'hFF
`define SNFR_OP_POR_ENABLE 8'h66
`define SNFR_OP_POR 8'h99

// ----------------------------------------------------------------
// Feature addresses
// ----------------------------------------------------------------
`define SNFR_ADDR_PROT 8'hA0
`define SNFR_ADDR_CONFIG 8'hB0
`define SNFR_ADDR_STATUS 8'hC0
`define SNFR_ADDR_DRIVE 8'hD0
`define SNFR_ADDR_EXT 8'hF0

// ----------------------------------------------------------------
// Bit positions
// ----------------------------------------------------------------
`define SNFR_PROT_LOCK_BIT 7
`define SNFR_PROT_BP2_BIT 5
`define SNFR_PROT_BP0_BIT 3
`define SNFR_PROT_INV_BIT 2
`define SNFR_PROT_CMP_BIT 1
`define SNFR_CFG_OTP_LOCK_BIT 7
`define SNFR_CFG_OTP_EN_BIT 6
`define SNFR_CFG_ECC_EN_BIT 4
`define SNFR_CFG_BPL_BIT 3
`define SNFR_CFG_QE_BIT 0

// ----------------------------------------------------------------
// Writable masks and power-up values
// ----------------------------------------------------------------
`define SNFR_PROT_MASK 8'hBE
`define SNFR_CFG_MASK 8'hD9
`define SNFR_DRIVE_MASK 8'h60
`define SNFR_PROT_RESET 8'h38
`define SNFR_CFG_RESET 8'h10
`define SNFR_DRIVE_RESET 8'h00
`define SNFR_ECC_NONE 2'h0

`endif

/* File: hw/snfr_pkg.sv */
/*
 Types for the feature register bank.
 Assumes snfr_defines.svh is compiled alongside.
*/
package snfr_pkg;

  typedef enum logic [2:0] {
    SNFR_OPCODE = 3'h0,
    SNFR_ADDR = 3'h1,
    SNFR_WDATA = 3'h2,
    SNFR_RDATA = 3'h3,
    SNFR_IGNORE = 3'h4
  } snfr_phase_type;

  typedef struct packed {
    logic [7:0] shift;
    logic [2:0] count;
    logic [7:0] opcode;
    logic [7:0] addr;
    snfr_phase_type phase;
    logic wr_pending;
    logic [7:0] wr_data;
    logic [7:0] out_byte;
    logic sdo;
    logic sdo_oe_n;
    logic cmd_done;
  } snfr_frame_type;

endpackage

/* File: hw/snfr_sync.sv */
/*
 Two-stage synchroniser for one level.
 Assumes an asynchronous active-high reset.
*/
`timescale 1ns/1ps
module snfr_sync (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic async_in,
  output logic sync_out
);
  logic [1:0] stage_ff;
  logic [1:0] nxt_stage;

  always_comb begin
    nxt_stage = {stage_ff[0], async_in};
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      stage_ff <= 2'h0;
    end else begin
      stage_ff <= nxt_stage;
    end
  end

  assign sync_out = stage_ff[1];
endmodule

/* File: hw/snfr_frame.sv */
/*
 Serial frame engine: shifts opcode, address and data in MSB first,
 shifts the selected feature byte out. Runs on the block clock and steps
 on each detected serial clock rise; frame pins arrive synchronised.
*/
`timescale 1ns/1ps
`include "snfr_defines.svh"
module snfr_frame (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic cs_n_in,
  input wire logic cs_fall_in,
  input wire logic sck_rise_in,
  input wire logic sdi_in,
  input wire logic [7:0] rd_byte_in,
  output logic [7:0] opcode_out,
  output logic [7:0] addr_out,
  output logic [7:0] wr_data_out,
  output logic wr_commit_out,
  output logic cmd_done_out,
  output logic [7:0] rd_addr_out,
  output logic sdo_out,
  output logic sdo_oe_n_out
);
  snfr_pkg::snfr_frame_type st_ff;
  snfr_pkg::snfr_frame_type nxt_st;
  logic [7:0] shifted;

  always_comb begin
    nxt_st = st_ff;
    shifted = {st_ff.shift[6:0], sdi_in};
    nxt_st.cmd_done = 1'b0;
    nxt_st.wr_pending = 1'b0;
    if (cs_n_in) begin
      // Frame end: a complete set-feature frame commits now
      nxt_st.wr_pending = st_ff.phase == snfr_pkg::SNFR_IGNORE &&
        st_ff.opcode == `SNFR_OP_SET_FEATURE;
      nxt_st.cmd_done = st_ff.phase != snfr_pkg::SNFR_OPCODE ||
        st_ff.count != 3'h0;
      nxt_st.phase = snfr_pkg::SNFR_OPCODE;
      nxt_st.count = 3'h0;
      nxt_st.sdo_oe_n = 1'b1;
    end else begin
      if (cs_fall_in) begin
        nxt_st.phase = snfr_pkg::SNFR_OPCODE;
        nxt_st.opcode = 8'h00;
      end
      if (sck_rise_in) begin
        nxt_st.shift = shifted;
        nxt_st.count = 3'(st_ff.count + 3'h1);
      end
      if (sck_rise_in && st_ff.phase == snfr_pkg::SNFR_RDATA) begin
        nxt_st.sdo_oe_n = 1'b0;
        if (st_ff.count == 3'h0) begin
          // Fresh byte at each boundary, so status polling stays live
          nxt_st.sdo = rd_byte_in[7];
          nxt_st.out_byte = {rd_byte_in[6:0], rd_byte_in[7]};
        end else begin
          nxt_st.sdo = st_ff.out_byte[7];
          nxt_st.out_byte = {st_ff.out_byte[6:0], st_ff.out_byte[7]};
        end
      end
      if (sck_rise_in && st_ff.count == 3'h7) begin
        unique case (st_ff.phase)
          snfr_pkg::SNFR_OPCODE: begin
            nxt_st.opcode = shifted;
            if (shifted == `SNFR_OP_GET_FEATURE ||
                shifted == `SNFR_OP_SET_FEATURE) begin
              nxt_st.phase = snfr_pkg::SNFR_ADDR;
            end else begin
              nxt_st.phase = snfr_pkg::SNFR_IGNORE;
            end
          end
          snfr_pkg::SNFR_ADDR: begin
            nxt_st.addr = shifted;
            if (st_ff.opcode == `SNFR_OP_GET_FEATURE) begin
              nxt_st.phase = snfr_pkg::SNFR_RDATA;
            end else begin
              nxt_st.phase = snfr_pkg::SNFR_WDATA;
            end
          end
          snfr_pkg::SNFR_WDATA: begin
            nxt_st.wr_data = shifted;
            nxt_st.phase = snfr_pkg::SNFR_IGNORE;
          end
          snfr_pkg::SNFR_RDATA: begin
            // Feature byte repeats while the host keeps clocking
          end
          snfr_pkg::SNFR_IGNORE: begin
          end
          default: begin
            nxt_st.phase = snfr_pkg::SNFR_IGNORE;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_ff <= '{shift: 8'h00, count: 3'h0, opcode: 8'h00, addr: 8'h00,
        phase: snfr_pkg::SNFR_OPCODE, wr_pending: 1'b0, wr_data: 8'h00,
        out_byte: 8'h00, sdo: 1'b0, sdo_oe_n: 1'b1, cmd_done: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign opcode_out = st_ff.opcode;
  assign addr_out = st_ff.addr;
  assign wr_data_out = st_ff.wr_data;
  assign wr_commit_out = st_ff.wr_pending;
  assign cmd_done_out = st_ff.cmd_done;
  assign rd_addr_out = st_ff.addr;
  assign sdo_out = st_ff.sdo;
  assign sdo_oe_n_out = st_ff.sdo_oe_n;
endmodule

/* File: verification/snfr_top_properties.sv */
/*
 Checker on the ports of the feature register bank top, bound below.
 Assumes one clock domain and an asynchronous active-high reset.
*/
`timescale 1ns/1ps
module snfr_top_properties (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic cs_n_in,
  input wire logic wp_n_in,
  input wire logic prog_start_in,
  input wire logic erase_start_in,
  input wire logic sdo_oe_n_out,
  input wire logic [7:0] block_protection_reg_out,
  input wire logic [7:0] device_config_reg_out,
  input wire logic [1:0] drive_strength_select_out,
  input wire logic ecc_enable_out,
  input wire logic quad_io_enable_out,
  input wire logic write_enable_latch_out,
  input wire logic otp_lock_commit_out
);
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (rst_in);
  // ------------------------------------------------
  // Register bank properties
  // ------------------------------------------------
  property p_power_up;
    $fell(rst_in) |-> block_protection_reg_out == 8'h38 && ecc_enable_out
      && !quad_io_enable_out && !write_enable_latch_out
      && drive_strength_select_out == 2'h0;
  endproperty
  a_power_up: assert property (p_power_up)
    else $error("power-up values wrong");
  property p_lock_hold;
    !wp_n_in && block_protection_reg_out[7]
      |=> $stable(block_protection_reg_out);
  endproperty
  a_lock_hold: assert property (p_lock_hold)
    else $error("locked protection byte changed");
  property p_lockdown;
    $past(device_config_reg_out[3]) && device_config_reg_out[3]
      |-> $stable(block_protection_reg_out);
  endproperty
  a_lockdown: assert property (p_lockdown)
    else $error("protection byte changed under lockdown");
  property p_wel_prog;
    prog_start_in || erase_start_in |=> !write_enable_latch_out;
  endproperty
  a_wel_prog: assert property (p_wel_prog)
    else $error("latch kept after array start");
  property p_wel_rise;
    $rose(write_enable_latch_out) |-> $past(cs_n_in, 2);
  endproperty
  a_wel_rise: assert property (p_wel_rise)
    else $error("latch set inside a frame");
  property p_ds_commit;
    $changed(drive_strength_select_out) |-> $past(cs_n_in, 2);
  endproperty
  a_ds_commit: assert property (p_ds_commit)
    else $error("drive strength changed inside a frame");
  property p_sdo_idle;
    cs_n_in [*6] |-> sdo_oe_n_out;
  endproperty
  a_sdo_idle: assert property (p_sdo_idle)
    else $error("serial output driven while deselected");
  property p_otp_commit;
    otp_lock_commit_out |-> &device_config_reg_out[7:6];
  endproperty
  a_otp_commit: assert property (p_otp_commit)
    else $error("otp commit without enable and lock");
endmodule
bind snfr_top snfr_top_properties chk (
  .clk_in(clk_in), .rst_in(rst_in), .cs_n_in(cs_n_in), .wp_n_in(wp_n_in),
  .prog_start_in(prog_start_in), .erase_start_in(erase_start_in),
  .sdo_oe_n_out(sdo_oe_n_out),
  .block_protection_reg_out(block_protection_reg_out),
  .device_config_reg_out(device_config_reg_out),
  .drive_strength_select_out(drive_strength_select_out),
  .ecc_enable_out(ecc_enable_out), .quad_io_enable_out(quad_io_enable_out),
  .write_enable_latch_out(write_enable_latch_out),
  .otp_lock_commit_out(otp_lock_commit_out)
);

/* File: verification/snfr_host.sv */
/*
 Serial host model: sends frames MSB first and shifts in read bytes.
 Assumes the bank clock and the design's registered serial output.
*/
`timescale 1ns/1ps
module snfr_host (
  input wire logic clk_in,
  input wire logic sdo_in,
  input wire logic sdo_oe_n_in,
  output logic cs_n_out,
  output logic sck_out,
  output logic sdi_out
);
  initial begin
    cs_n_out = 1'b1;
    sck_out = 1'b0;
    sdi_out = 1'b1;
  end
  // Serial clock only runs inside a frame, 5 cycles per phase
  task automatic xfer(input logic [31:0] bits, input int n,
                      output logic [7:0] rd);
    rd = 8'h00;
    @(posedge clk_in);
    cs_n_out <= 1'b0;
    for (int i = 0; i < n; i++) begin
      sdi_out <= bits[31 - i];
      repeat (5) @(posedge clk_in);
      if (i > 16)
        rd = {rd[6:0], sdo_oe_n_in ? 1'bx : sdo_in};
      sck_out <= 1'b1;
      repeat (5) @(posedge clk_in);
      sck_out <= 1'b0;
    end
    repeat (5) @(posedge clk_in);
    cs_n_out <= 1'b1;
    sdi_out <= ~sdi_out;
    repeat (12) @(posedge clk_in);
  endtask
endmodule

/* File: verification/test_serial_nand_feature_registers.sv */
/*
 Table-driven bench for the feature register bank top.
 Assumes the host model and the bound checker are compiled first.
*/
`timescale 1ns/1ps
`include "snfr_defines.svh"
module test_serial_nand_feature_registers;
  typedef struct packed {
    logic wr;
    logic [7:0] wa, wd, ra, msk, ex;
  } snfr_row_type;
  logic clk_in, rst_in, otp_st, cs_n, sck, sdi, wp_n, busy, bprot;
  logic sdo, sdo_oe_n, otp_cm, soft_rst, ecc_en, qe, wel_o;
  logic [5:0] ev;
  logic [3:0] ecc;
  logic [7:0] a0, b0;
  logic [1:0] ds;
  int n_errors = 0;
  int n_tests = 0;
  int n_sr = 0;
  int n_otp = 0;
  snfr_row_type rows [13] = '{
    '{1'b0, 8'h00, 8'h00, 8'hA0, 8'hFF, 8'h38},
    '{1'b0, 8'h00, 8'h00, 8'hB0, 8'hFF, 8'h10},
    '{1'b0, 8'h00, 8'h00, 8'hD0, 8'hFF, 8'h00},
    '{1'b0, 8'h00, 8'h00, 8'hC0, 8'hFF, 8'h00},
    '{1'b0, 8'h00, 8'h00, 8'hF0, 8'h10, 8'h10},
    '{1'b1, 8'hA0, 8'h00, 8'hA0, 8'hFF, 8'h00},
    '{1'b1, 8'hB0, 8'h01, 8'hB0, 8'hFF, 8'h01},
    '{1'b1, 8'hD0, 8'h20, 8'hD0, 8'hFF, 8'h20},
    '{1'b1, 8'hD0, 8'h40, 8'hD0, 8'hFF, 8'h40},
    '{1'b1, 8'hD0, 8'h60, 8'hD0, 8'hFF, 8'h60},
    '{1'b1, 8'hC0, 8'h3F, 8'hC0, 8'hFF, 8'h00},
    '{1'b1, 8'hF0, 8'h70, 8'hD0, 8'hFF, 8'h60},
    '{1'b1, 8'h55, 8'hFF, 8'hA0, 8'hFF, 8'h00}
  };
  snfr_top dut (
    .clk_in(clk_in), .rst_in(rst_in), .otp_lock_stored_in(otp_st),
    .cs_n_in(cs_n), .sck_in(sck), .sdi_in(sdi), .wp_n_in(wp_n),
    .eng_busy_in(busy), .read_start_in(ev[5]), .read_done_in(ev[4]),
    .read_ecc_in(ecc), .prog_start_in(ev[3]), .prog_fail_in(ev[2]),
    .erase_start_in(ev[1]), .erase_fail_in(ev[0]),
    .block_protected_in(bprot), .sdo_out(sdo), .sdo_oe_n_out(sdo_oe_n),
    .block_protection_reg_out(a0), .device_config_reg_out(b0),
    .drive_strength_select_out(ds), .ecc_enable_out(ecc_en),
    .quad_io_enable_out(qe), .write_enable_latch_out(wel_o),
    .otp_lock_commit_out(otp_cm), .soft_reset_out(soft_rst)
  );
  snfr_host host (
    .clk_in(clk_in), .sdo_in(sdo), .sdo_oe_n_in(sdo_oe_n),
    .cs_n_out(cs_n), .sck_out(sck), .sdi_out(sdi)
  );
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    if (soft_rst === 1'b1) n_sr++;
    if (otp_cm === 1'b1) n_otp++;
  end
  // ------------------------------------------------
  // Shared tasks
  // ------------------------------------------------
  task automatic close_out();
    $display("tests %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmd(input logic [7:0] op);
    logic [7:0] r;
    host.xfer({op, 24'h000000}, 8, r);
  endtask
  task automatic setf(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    host.xfer({`SNFR_OP_SET_FEATURE, a, d, 8'h00}, 24, r);
  endtask
  task automatic chk(input logic [7:0] a, m, e);
    logic [7:0] r;
    host.xfer({`SNFR_OP_GET_FEATURE, a, 16'h0000}, 25, r);
    cmp(r & m, e);
  endtask
  task automatic pulse(input logic [5:0] m);
    @(posedge clk_in) ev <= m;
    @(posedge clk_in) ev <= 6'h00;
  endtask
  task automatic do_reset();
    rst_in <= 1'b1;
    repeat (6) @(posedge clk_in);
    rst_in <= 1'b0;
    repeat (4) @(posedge clk_in);
  endtask
  initial begin
    repeat (30000) @(posedge clk_in);
    n_errors++;
    close_out();
  end
  // ------------------------------------------------
  // Main sequence
  // ------------------------------------------------
  initial begin
    rst_in = 1'b1;
    otp_st = 1'b0;
    wp_n = 1'b1;
    busy = 1'b0;
    bprot = 1'b1;
    ev = 6'h00;
    ecc = 4'h0;
    do_reset();
    foreach (rows[i]) begin
      if (rows[i].wr)
        setf(rows[i].wa, rows[i].wd);
      chk(rows[i].ra, rows[i].msk, rows[i].ex);
    end
    cmp({4'h0, ds, qe, ecc_en}, 8'h0E);
    $display("test table done");
    cmd(`SNFR_OP_WRITE_ENABLE);
    cmp({7'h00, wel_o}, 8'h01);
    chk(`SNFR_ADDR_STATUS, 8'h02, 8'h02);
    cmd(`SNFR_OP_WRITE_DISABLE);
    chk(`SNFR_ADDR_STATUS, 8'h02, 8'h00);
    cmd(`SNFR_OP_WRITE_ENABLE);
    pulse(6'h08);
    chk(`SNFR_ADDR_STATUS, 8'h02, 8'h00);
    pulse(6'h04);
    chk(`SNFR_ADDR_STATUS, 8'h08, 8'h08);
    pulse(6'h08);
    chk(`SNFR_ADDR_STATUS, 8'h08, 8'h00);
    pulse(6'h01);
    chk(`SNFR_ADDR_STATUS, 8'h04, 8'h04);
    pulse(6'h02);
    chk(`SNFR_ADDR_STATUS, 8'h04, 8'h00);
    @(posedge clk_in) busy <= 1'b1;
    chk(`SNFR_ADDR_STATUS, 8'h01, 8'h01);
    @(posedge clk_in) busy <= 1'b0;
    chk(`SNFR_ADDR_STATUS, 8'h01, 8'h00);
    $display("test status done");
    setf(`SNFR_ADDR_CONFIG, 8'h10);
    for (int c = 0; c < 4; c++) begin
      @(posedge clk_in) ecc <= {c[1:0], 2'h2};
      pulse(6'h10);
      chk(`SNFR_ADDR_STATUS, 8'h30, {2'h0, c[1:0], 4'h0});
      if (c == 1)
        chk(`SNFR_ADDR_EXT, 8'h60, 8'h40);
    end
    pulse(6'h20);
    chk(`SNFR_ADDR_STATUS, 8'h30, 8'h00);
    $display("test ecc done");
    pulse(6'h05);
    cmd(`SNFR_OP_WRITE_ENABLE);
    cmd(`SNFR_OP_SOFT_RESET);
    repeat (16) @(posedge clk_in);
    chk(`SNFR_ADDR_STATUS, 8'h0E, 8'h00);
    chk(`SNFR_ADDR_DRIVE, 8'hFF, 8'h60);
    chk(`SNFR_ADDR_CONFIG, 8'hFF, 8'h10);
    cmp(8'(n_sr), 8'h01);
    $display("test soft reset done");
    setf(`SNFR_ADDR_PROT, 8'h80);
    @(posedge clk_in) wp_n <= 1'b0;
    setf(`SNFR_ADDR_PROT, 8'h38);
    chk(`SNFR_ADDR_PROT, 8'hFF, 8'h80);
    @(posedge clk_in) wp_n <= 1'b1;
    setf(`SNFR_ADDR_PROT, 8'h00);
    chk(`SNFR_ADDR_PROT, 8'hFF, 8'h00);
    setf(`SNFR_ADDR_CONFIG, 8'h18);
    setf(`SNFR_ADDR_PROT, 8'h38);
    chk(`SNFR_ADDR_PROT, 8'hFF, 8'h00);
    cmd(`SNFR_OP_POR_ENABLE);
    cmd(`SNFR_OP_POR);
    repeat (64) @(posedge clk_in);
    chk(`SNFR_ADDR_PROT, 8'hFF, 8'h38);
    chk(`SNFR_ADDR_CONFIG, 8'hFF, 8'h10);
    chk(`SNFR_ADDR_DRIVE, 8'hFF, 8'h00);
    cmp(8'(n_sr), 8'h02);
    $display("test protection done");
    setf(`SNFR_ADDR_CONFIG, 8'hC0);
    cmd(`SNFR_OP_WRITE_ENABLE);
    pulse(6'h08);
    repeat (4) @(posedge clk_in);
    cmp(8'(n_otp), 8'h01);
    @(posedge clk_in) otp_st <= 1'b1;
    do_reset();
    chk(`SNFR_ADDR_CONFIG, 8'hC0, 8'h80);
    chk(`SNFR_ADDR_PROT, 8'hFF, 8'h38);
    cmp(a0, 8'h38);
    cmp(b0, 8'h90);
    $display("test otp done");
    close_out();
  end
endmodule
